/* scr_pkg.sv */
// Package for the serial chip configuration register bank
`default_nettype none
package scr_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ             = 25_000_000;
  localparam int unsigned SOFT_RESET_WAIT_MS = 5;
  localparam int unsigned BOOT_CYCLES        = SOFT_RESET_WAIT_MS * (CLK_HZ / 1000);
  localparam logic [4:0]  DP_RESET_CYCLES    = 5'h10;

  // Register addresses (15-bit serial address space)
  localparam logic [14:0] ADDR_SERIAL_CFG_LOW = 15'h0000;
  localparam logic [14:0] ADDR_SERIAL_DP_RST  = 15'h0001;
  localparam logic [14:0] ADDR_CHAN_POWER     = 15'h0002;
  localparam logic [14:0] ADDR_PRODUCT_CLASS  = 15'h0003;

  // Field positions
  localparam int unsigned SOFT_RST_BIT  = 0;
  localparam int unsigned LSB_FIRST_BIT = 1;
  localparam int unsigned DP_RST_BIT    = 1;
  localparam int unsigned INST_RD_BIT   = 15;

  // Values after reset
  localparam logic        LSB_FIRST_RST = 1'b0;
  localparam logic [7:0]  RSVD_READ     = 8'h00;

  // Serial frame lengths
  localparam logic [3:0]  INST_LAST_BIT = 4'hF;
  localparam logic [3:0]  DATA_LAST_BIT = 4'h7;
  localparam logic [3:0]  DATA_BITS     = 4'h8;

  typedef enum logic [1:0] {
    SCR_PWR_NORMAL  = 2'b00,
    SCR_PWR_RSVD    = 2'b01,
    SCR_PWR_STANDBY = 2'b10,
    SCR_PWR_DOWN    = 2'b11
  } scr_pwr_e;

  localparam scr_pwr_e PWR_RST = SCR_PWR_NORMAL;

  typedef enum logic [2:0] {
    SCR_ST_IDLE  = 3'b000,
    SCR_ST_INST  = 3'b001,
    SCR_ST_WRITE = 3'b010,
    SCR_ST_READ  = 3'b011,
    SCR_ST_DONE  = 3'b100
  } scr_state_e;

  typedef struct packed {
    logic        wr;
    logic [14:0] addr;
    logic [7:0]  data;
  } scr_req_s;

endpackage
`default_nettype wire

/* scr_sync.sv */
// Two-flop synchroniser for serial port pins
`timescale 1ns/10ps
`default_nettype none
module scr_sync #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_clk_en,
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1)
    begin : g_bit
      always_ff @(posedge i_sys_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          meta_reg[gi] <= RST_VAL[gi];
          o_sync[gi]   <= RST_VAL[gi];
        end
        else if (i_clk_en)
        begin
          meta_reg[gi] <= i_async[gi];
          o_sync[gi]   <= meta_reg[gi];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* scr_chip_regs.sv */
// Serial control port slave with chip configuration registers
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Shift-order bit set: instruction and data travel least significant bit first.
// - Shift-order bit clear, the reset value: most significant bit first.
// - Writing 1 to bit 0 at address 0 resets port and registers; self clears.
// - Writing 1 to bit 1 at address 1 resets only the datapath; self clears.
// - Power mode 00 is normal, 10 is standby with datapath clocks stopped.
// - In standby the serial output link keeps running.
// - Power mode 11 stops datapath clocks and holds datapath in reset.
// - Power mode 11 also disables the serial output link.
module scr_chip_regs #(
  parameter int unsigned BOOT_CYCLES = scr_pkg::BOOT_CYCLES,
  parameter logic [7:0]  CHIP_TYPE   = 8'h5A  // Arbitrary class code
) (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_clk_en,
  input  wire logic i_spi_sclk,
  input  wire logic i_spi_csb_n,
  input  wire logic i_spi_sdio,
  output var  logic o_spi_sdio,
  output var  logic o_spi_sdio_oe,
  output var  logic o_dp_clk_en,
  output var  logic o_dp_reset,
  output var  logic o_link_en,
  output var  logic o_boot_busy
);

  logic                 sclk_s;
  logic                 csb_n_s;
  logic                 sdi_s;
  logic                 sclk_prev_reg;
  logic                 sclk_rise;
  logic                 sclk_fall;
  scr_pkg::scr_state_e  state_reg;
  logic [3:0]           bit_cnt_reg;
  logic [15:0]          inst_reg;
  logic [15:0]          inst_next;
  logic [7:0]           rx_reg;
  logic [7:0]           rx_next;
  logic [7:0]           tx_reg;
  scr_pkg::scr_req_s    req_reg;
  logic                 lsb_first_reg;
  scr_pkg::scr_pwr_e    pwr_reg;
  logic [31:0]          boot_cnt_reg;
  logic [4:0]           dp_cnt_reg;
  logic                 boot_busy;
  logic                 dp_busy;

  // Pins come from another domain, so two flops before any use
  scr_sync #(
    .W       (3),
    .RST_VAL (3'b010)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_clk_en  (i_clk_en),
    .i_async   ({i_spi_sclk, i_spi_csb_n, i_spi_sdio}),
    .o_sync    ({sclk_s, csb_n_s, sdi_s})
  );

  function automatic logic [7:0] read_mux(input logic [14:0] addr);
    logic [7:0] v;
    v = scr_pkg::RSVD_READ;
    if (addr == scr_pkg::ADDR_SERIAL_CFG_LOW)
    begin
      v[scr_pkg::LSB_FIRST_BIT] = lsb_first_reg;
      v[scr_pkg::SOFT_RST_BIT]  = boot_busy;
    end
    else if (addr == scr_pkg::ADDR_SERIAL_DP_RST)
      v[scr_pkg::DP_RST_BIT] = dp_busy;
    else if (addr == scr_pkg::ADDR_CHAN_POWER)
      v[1:0] = pwr_reg;
    else if (addr == scr_pkg::ADDR_PRODUCT_CLASS)
      v = CHIP_TYPE;
    return v;
  endfunction

  assign boot_busy = (boot_cnt_reg != 32'h0000_0000);
  assign dp_busy   = (dp_cnt_reg != 5'h00);
  assign sclk_rise = sclk_s & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_s & sclk_prev_reg;

  // Bit order is chosen per bit, so a mode write applies from the next frame on
  always_comb
  begin
    if (lsb_first_reg)
    begin
      inst_next = {sdi_s, inst_reg[15:1]};
      rx_next   = {sdi_s, rx_reg[7:1]};
    end
    else
    begin
      inst_next = {inst_reg[14:0], sdi_s};
      rx_next   = {rx_reg[6:0], sdi_s};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      sclk_prev_reg <= 1'b0;
    else if (i_clk_en)
      sclk_prev_reg <= sclk_s;
  end

  // Serial frame engine; single byte per frame, extra clocks ignored
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg   <= scr_pkg::SCR_ST_IDLE;
      bit_cnt_reg <= 4'h0;
      inst_reg    <= 16'h0000;
      rx_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      req_reg     <= '0;
    end
    else if (i_clk_en)
    begin
      req_reg.wr <= 1'b0;
      if (boot_busy || csb_n_s)
      begin
        state_reg   <= scr_pkg::SCR_ST_IDLE;
        bit_cnt_reg <= 4'h0;
      end
      else
      begin
        case (state_reg)
          scr_pkg::SCR_ST_IDLE:
          begin
            state_reg   <= scr_pkg::SCR_ST_INST;
            bit_cnt_reg <= 4'h0;
          end
          scr_pkg::SCR_ST_INST:
          begin
            if (sclk_rise)
            begin
              inst_reg    <= inst_next;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == scr_pkg::INST_LAST_BIT)
              begin
                if (inst_next[scr_pkg::INST_RD_BIT])
                begin
                  tx_reg    <= read_mux(inst_next[14:0]);
                  state_reg <= scr_pkg::SCR_ST_READ;
                end
                else
                  state_reg <= scr_pkg::SCR_ST_WRITE;
              end
            end
          end
          scr_pkg::SCR_ST_WRITE:
          begin
            if (sclk_rise)
            begin
              rx_reg      <= rx_next;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == scr_pkg::DATA_LAST_BIT)
              begin
                req_reg.wr   <= 1'b1;
                req_reg.addr <= inst_reg[14:0];
                req_reg.data <= rx_next;
                state_reg    <= scr_pkg::SCR_ST_DONE;
              end
            end
          end
          scr_pkg::SCR_ST_READ:
          begin
            if (sclk_fall)
            begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (lsb_first_reg)
                tx_reg <= {1'b0, tx_reg[7:1]};
              else
                tx_reg <= {tx_reg[6:0], 1'b0};
              if (bit_cnt_reg == scr_pkg::DATA_BITS)
                state_reg <= scr_pkg::SCR_ST_DONE;
            end
          end
          default:
            state_reg <= scr_pkg::SCR_ST_DONE;
        endcase
      end
    end
  end

  // Read data leaves on the falling edge so the host samples it on the rise
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_spi_sdio    <= 1'b0;
      o_spi_sdio_oe <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (boot_busy || csb_n_s || state_reg != scr_pkg::SCR_ST_READ)
        o_spi_sdio_oe <= 1'b0;
      else if (sclk_fall)
      begin
        if (bit_cnt_reg < scr_pkg::DATA_BITS)
        begin
          o_spi_sdio    <= lsb_first_reg ? tx_reg[0] : tx_reg[7];
          o_spi_sdio_oe <= 1'b1;
        end
        else
          o_spi_sdio_oe <= 1'b0;
      end
    end
  end

  // Full soft reset; the whole boot wait keeps the port deaf to the host
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      boot_cnt_reg <= 32'h0000_0000;
    else if (i_clk_en)
    begin
      if (req_reg.wr && req_reg.addr == scr_pkg::ADDR_SERIAL_CFG_LOW
          && req_reg.data[scr_pkg::SOFT_RST_BIT])
        boot_cnt_reg <= BOOT_CYCLES;
      else if (boot_busy)
        boot_cnt_reg <= boot_cnt_reg - 32'h0000_0001;
    end
  end

  // Datapath-only reset pulse; a new request restarts the count
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      dp_cnt_reg <= 5'h00;
    else if (i_clk_en)
    begin
      if (boot_busy)
        dp_cnt_reg <= 5'h00;
      else if (req_reg.wr && req_reg.addr == scr_pkg::ADDR_SERIAL_DP_RST
               && req_reg.data[scr_pkg::DP_RST_BIT])
        dp_cnt_reg <= scr_pkg::DP_RESET_CYCLES;
      else if (dp_busy)
        dp_cnt_reg <= dp_cnt_reg - 5'h01;
    end
  end

  // Writable fields; only the documented bits are stored
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lsb_first_reg <= scr_pkg::LSB_FIRST_RST;
      pwr_reg       <= scr_pkg::PWR_RST;
    end
    else if (i_clk_en)
    begin
      if (boot_busy)
      begin
        lsb_first_reg <= scr_pkg::LSB_FIRST_RST;
        pwr_reg       <= scr_pkg::PWR_RST;
      end
      else if (req_reg.wr && req_reg.addr == scr_pkg::ADDR_SERIAL_CFG_LOW)
        lsb_first_reg <= req_reg.data[scr_pkg::LSB_FIRST_BIT];
      else if (req_reg.wr && req_reg.addr == scr_pkg::ADDR_CHAN_POWER)
        pwr_reg <= scr_pkg::scr_pwr_e'(req_reg.data[1:0]);
    end
  end

  // Undefined code 01 behaves as normal mode
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_dp_clk_en <= 1'b1;
      o_dp_reset  <= 1'b0;
      o_link_en   <= 1'b1;
      o_boot_busy <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_dp_clk_en <= !(pwr_reg == scr_pkg::SCR_PWR_STANDBY
                       || pwr_reg == scr_pkg::SCR_PWR_DOWN);
      o_dp_reset  <= (pwr_reg == scr_pkg::SCR_PWR_DOWN) || dp_busy || boot_busy;
      o_link_en   <= (pwr_reg != scr_pkg::SCR_PWR_DOWN);
      o_boot_busy <= boot_busy;
    end
  end

endmodule
`default_nettype wire

/* scr_chip_regs_props.sv */
// Assertion checker for the chip configuration register bank
`timescale 1ns/10ps
`default_nettype none
module scr_chip_regs_props #(
  parameter int unsigned BOOT_CYCLES = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_spi_sclk,
  input wire logic i_spi_csb_n,
  input wire logic i_spi_sdio,
  input wire logic o_spi_sdio,
  input wire logic o_spi_sdio_oe,
  input wire logic o_dp_clk_en,
  input wire logic o_dp_reset,
  input wire logic o_link_en,
  input wire logic o_boot_busy
);
  int unsigned busy_cnt;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  // Boot wait is too long for a repetition, so it is counted
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn)
      busy_cnt <= 0;
    else if (i_clk_en)
      busy_cnt <= o_boot_busy ? busy_cnt + 1 : 0;

  a_reset_defaults: assert property ($rose(i_resetn) |-> o_dp_clk_en && o_link_en
    && !o_dp_reset && !o_boot_busy && !o_spi_sdio_oe) else $error("outputs not at defaults");
  a_down_link_off: assert property (!o_link_en |-> !o_dp_clk_en && o_dp_reset)
    else $error("link off outside power down");
  a_standby_link: assert property (!o_dp_clk_en && !o_dp_reset |-> o_link_en)
    else $error("link off in standby");
  a_boot_dp_hold: assert property (o_boot_busy |-> o_dp_reset)
    else $error("datapath free during boot");
  a_boot_deaf: assert property (o_boot_busy |-> !o_spi_sdio_oe)
    else $error("port drives during boot");
  a_boot_length: assert property ($fell(o_boot_busy) |-> busy_cnt == BOOT_CYCLES)
    else $error("boot wait length wrong");
  a_dp_pulse: assert property ($rose(o_dp_reset) && o_dp_clk_en && !o_boot_busy
    |-> o_dp_reset[*8]) else $error("datapath reset pulse too short");
  a_oe_selected: assert property (o_spi_sdio_oe |-> !$past(i_spi_csb_n, 6))
    else $error("data driven while deselected");
endmodule

bind scr_chip_regs scr_chip_regs_props #(.BOOT_CYCLES(BOOT_CYCLES)) i_scr_chip_regs_props (
  .i_sys_clk, .i_resetn, .i_clk_en, .i_spi_sclk, .i_spi_csb_n, .i_spi_sdio, .o_spi_sdio,
  .o_spi_sdio_oe, .o_dp_clk_en, .o_dp_reset, .o_link_en, .o_boot_busy);
`default_nettype wire

/* scr_host.sv */
// Serial control port host model
`timescale 1ns/10ps
`default_nettype none
module scr_host #(
  parameter int unsigned BOOT_CYCLES = 20
) (
  input  wire logic i_sys_clk,
  input  wire logic i_sdio,
  output var  logic o_sclk,
  output var  logic o_csb_n,
  output var  logic o_sdio
);
  localparam int unsigned HALF = 6;

  initial
  begin
    o_sclk = 1'b0;
    o_csb_n = 1'b1;
    o_sdio = 1'b0;
  end

  task automatic boot_wait();
    repeat (BOOT_CYCLES) @(negedge i_sys_clk);
  endtask

  // One byte per frame; released data line toggles so stale values never pass
  task automatic xfer(input logic lsb, input logic wr, input logic [14:0] addr,
                      input logic [7:0] data, output logic [7:0] rd);
    logic [15:0] inst;
    inst = {~wr, addr};
    rd = 8'h00;
    @(negedge i_sys_clk);
    o_csb_n = 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      if (i < 16)
        o_sdio = inst[lsb ? i : 15 - i];
      else
        o_sdio = wr ? data[lsb ? i - 16 : 23 - i] : ~o_sdio;
      repeat (HALF) @(negedge i_sys_clk);
      o_sclk = 1'b1;
      if (i > 15)
        rd[lsb ? i - 16 : 23 - i] = i_sdio;
      repeat (HALF) @(negedge i_sys_clk);
      o_sclk = 1'b0;
    end
    o_sdio = ~o_sdio;
    repeat (HALF) @(negedge i_sys_clk);
    o_csb_n = 1'b1;
    repeat (HALF) @(negedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// Testbench for the chip configuration register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int unsigned BOOT    = 600;
  localparam logic [7:0]  CTYPE   = 8'hA7;  // Arbitrary class code
  localparam logic [15:0] PWR_EXP = 16'h42AA;

  logic clk;
  logic rst_n;
  logic sclk;
  logic csb_n;
  logic host_sdio;
  logic dev_sdio;
  logic dev_oe;
  logic sdio_w;
  logic dp_clk_en;
  logic dp_reset;
  logic link_en;
  logic boot_busy;
  int   fail_count;
  int   cmp_count;

  assign sdio_w = dev_oe ? dev_sdio : host_sdio;

  scr_chip_regs #(.BOOT_CYCLES(BOOT), .CHIP_TYPE(CTYPE)) i_scr_chip_regs (
    .i_sys_clk(clk), .i_resetn(rst_n), .i_clk_en(1'b1), .i_spi_sclk(sclk),
    .i_spi_csb_n(csb_n), .i_spi_sdio(sdio_w), .o_spi_sdio(dev_sdio), .o_spi_sdio_oe(dev_oe),
    .o_dp_clk_en(dp_clk_en), .o_dp_reset(dp_reset), .o_link_en(link_en),
    .o_boot_busy(boot_busy));
  scr_host #(.BOOT_CYCLES(BOOT)) i_scr_host (.i_sys_clk(clk), .i_sdio(sdio_w),
    .o_sclk(sclk), .o_csb_n(csb_n), .o_sdio(host_sdio));

  always #20 clk = ~clk;

  function automatic logic [7:0] outs();
    return {4'h0, dp_clk_en, dp_reset, link_en, boot_busy};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic t_defaults();
    logic [7:0] rd;
    chk(outs(), 8'h0A);
    i_scr_host.xfer(1'b0, 1'b0, 15'h0003, 8'h00, rd);
    chk(rd, CTYPE);
    i_scr_host.xfer(1'b0, 1'b0, 15'h0000, 8'h00, rd);
    chk(rd, 8'h00);
    i_scr_host.xfer(1'b0, 1'b0, 15'h0010, 8'h00, rd);
    chk(rd, 8'h00);
  endtask

  // Reserved bits written as ones must not stick
  task automatic t_power();
    logic [7:0] rd;
    for (int m = 0; m < 4; m++)
    begin
      i_scr_host.xfer(1'b0, 1'b1, 15'h0002, {6'h3F, m[1:0]}, rd);
      chk(outs(), {4'h0, PWR_EXP[m*4 +: 4]});
      i_scr_host.xfer(1'b0, 1'b0, 15'h0002, 8'h00, rd);
      chk(rd, {6'h00, m[1:0]});
    end
  endtask

  task automatic t_dp_reset();
    logic [7:0] rd;
    logic [7:0] n;
    n = 8'h00;
    i_scr_host.xfer(1'b0, 1'b1, 15'h0002, 8'h00, rd);
    fork
      i_scr_host.xfer(1'b0, 1'b1, 15'h0001, 8'hFF, rd);
      repeat (400) @(negedge clk) n = n + {7'h00, dp_reset};
    join
    chk(n, {3'h0, scr_pkg::DP_RESET_CYCLES});
    i_scr_host.xfer(1'b0, 1'b0, 15'h0001, 8'h00, rd);
    chk(rd, 8'h00);
  endtask

  task automatic t_lsb_soft();
    logic [7:0] rd;
    i_scr_host.xfer(1'b0, 1'b1, 15'h0000, 8'h02, rd);
    i_scr_host.xfer(1'b1, 1'b0, 15'h0003, 8'h00, rd);
    chk(rd, CTYPE);
    i_scr_host.xfer(1'b1, 1'b0, 15'h0000, 8'h00, rd);
    chk(rd, 8'h02);
    i_scr_host.xfer(1'b1, 1'b1, 15'h0002, 8'h03, rd);
    i_scr_host.xfer(1'b1, 1'b1, 15'h0000, 8'h81, rd);
    // Boot restores power mode 00, so clocks and link come back
    chk(outs(), 8'h0F);
    // Too early on purpose, must be dropped
    i_scr_host.xfer(1'b0, 1'b1, 15'h0002, 8'h02, rd);
    i_scr_host.boot_wait();
    chk(outs(), 8'h0A);
    i_scr_host.xfer(1'b0, 1'b0, 15'h0000, 8'h00, rd);
    chk(rd, 8'h00);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_defaults();
    t_power();
    t_dp_reset();
    t_lsb_soft();
    test_done();
  end
endmodule
`default_nettype wire
